// >>> design/spra_map.vh
// Function
// - On menu entry, display alternates threshold one label and value until touched.
// - Up/down adjust items; program advances value, delays, band, pump, then next.
// - Relay one energizes only after alarm held unbroken for the make delay.
// - Relay one releases only after alarm absent unbroken for the break delay.
// - Each threshold keeps its own band enable, toggled by up/down.
// - Pump mode with threshold two above one bands relay one between them.
// - Pump fill: relay one on below threshold one, off at threshold two.
// - Pump drain: relay one on above threshold two, off at threshold one.
// - Thresholds three and four have no delays; menu offers value then band.
// - After threshold four band, menu shows stored activation polarity set.
// - Thresholds stay active for indication; operator parks unwanted ones at limits.
// - High polarity alarms above threshold; low polarity alarms below it.
// - Polarity characters map left to right onto thresholds four to one.
`ifndef SPRA_MAP_VH
`define SPRA_MAP_VH

`define SPRA_CLK_HZ 250000000
`define SPRA_TICK_S 1
`define SPRA_BLINK_MS 500

`define SPRA_VAL_MIN 16'shF831
`define SPRA_VAL_MAX 16'sh270F
`define SPRA_DLY_MIN 16'sh0000
`define SPRA_DLY_MAX 16'sh270F
`define SPRA_THR_RST 16'sh270F
`define SPRA_DLY_RST 16'sh0000
`define SPRA_POL_RST 4'hF

`define SPRA_M_IDLE 5'h00
`define SPRA_M_T1_VAL 5'h01
`define SPRA_M_T1_MAKE 5'h02
`define SPRA_M_T1_BREAK 5'h03
`define SPRA_M_T1_BAND 5'h04
`define SPRA_M_T1_PUMP 5'h05
`define SPRA_M_T2_VAL 5'h06
`define SPRA_M_T2_BAND 5'h07
`define SPRA_M_T3_VAL 5'h08
`define SPRA_M_T3_BAND 5'h09
`define SPRA_M_T4_VAL 5'h0A
`define SPRA_M_T4_BAND 5'h0B
`define SPRA_M_POL1 5'h0C
`define SPRA_M_POL2 5'h0D
`define SPRA_M_POL3 5'h0E
`define SPRA_M_POL4 5'h0F

`endif

// >>> design/spra_cmp.v
`include "spra_map.vh"
module spra_cmp (
    input wire clock_i,
    input wire rst_n_i,
    input wire sample_i,
    input wire signed [15:0] reading_i,
    input wire signed [15:0] thr_i,
    input wire signed [15:0] upper_thr_i,
    input wire band_enable_i,
    input wire [7:0] band_width_i,
    input wire high_pol_i,
    input wire pump_band_mode_i,
    output wire alarm_o
);
    wire signed [16:0] rd;
    wire signed [16:0] th;
    wire signed [16:0] wid;
    wire signed [16:0] lower;
    wire signed [16:0] upper;
    reg alarm_ff;
    reg nxt_alarm;

    assign rd = {reading_i[15], reading_i};
    assign th = {thr_i[15], thr_i};
    assign wid = band_enable_i ? {9'h000, band_width_i} : 17'h00000;
    assign lower = pump_band_mode_i ? th : th - wid;
    assign upper = pump_band_mode_i ? {upper_thr_i[15], upper_thr_i}
                                    : th + wid;
    assign alarm_o = alarm_ff;

    always @* begin
        nxt_alarm = alarm_ff;
        if (high_pol_i) begin
            if (rd > upper)
                nxt_alarm = 1'b1;
            else if (rd <= lower)
                nxt_alarm = 1'b0;
        end else begin
            if (rd < lower)
                nxt_alarm = 1'b1;
            else if (rd >= upper)
                nxt_alarm = 1'b0;
        end
    end

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i)
            alarm_ff <= 1'b0;
        else if (sample_i)
            alarm_ff <= nxt_alarm;
    end
endmodule // spra_cmp

// >>> design/spra_top.v
`include "spra_map.vh"
module spra_top #(
    parameter [31:0] TICK_CYCLES = `SPRA_CLK_HZ * `SPRA_TICK_S,
    parameter [31:0] BLINK_CYCLES = `SPRA_CLK_HZ / 1000 * `SPRA_BLINK_MS
) (
    input wire clock_i,
    input wire rst_n_i,
    input wire reading_valid_i,
    input wire signed [15:0] reading_i,
    input wire [7:0] band_width_i,
    input wire btn_prog_i,
    input wire btn_up_i,
    input wire btn_down_i,
    output wire [3:0] relay_o,
    output wire [3:0] lamp_o,
    output wire menu_active_o,
    output wire [4:0] menu_item_o,
    output wire disp_label_o,
    output wire [15:0] disp_value_o
);
    ////////////////////////////////////////////////////////////////////////
    // Reset release and button synchronisers
    reg [1:0] rst_sync_ff;
    wire rst_n;
    wire [2:0] btn_raw;
    reg [2:0] btn_s1_ff;
    reg [2:0] btn_s2_ff;
    reg [2:0] btn_old_ff;
    reg combo_old_ff;
    wire [2:0] btn_rise;
    wire combo_rise;
    wire prog_rise;
    wire up_rise;
    wire down_rise;
    genvar g;

    always @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i)
            rst_sync_ff <= 2'h0;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
    assign rst_n = rst_sync_ff[1];

    assign btn_raw = {btn_down_i, btn_up_i, btn_prog_i};
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_sync
            always @(posedge clock_i or negedge rst_n) begin
                if (!rst_n) begin
                    btn_s1_ff[g] <= 1'b0;
                    btn_s2_ff[g] <= 1'b0;
                    btn_old_ff[g] <= 1'b0;
                end else begin
                    btn_s1_ff[g] <= btn_raw[g];
                    btn_s2_ff[g] <= btn_s1_ff[g];
                    btn_old_ff[g] <= btn_s2_ff[g];
                end
            end
        end
    endgenerate

    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n)
            combo_old_ff <= 1'b0;
        else
            combo_old_ff <= btn_s2_ff[0] & btn_s2_ff[2];
    end
    assign btn_rise = btn_s2_ff & ~btn_old_ff;
    assign combo_rise = btn_s2_ff[0] & btn_s2_ff[2] & ~combo_old_ff;
    assign prog_rise = btn_rise[0] & ~btn_s2_ff[2];
    assign up_rise = btn_rise[1];
    assign down_rise = btn_rise[2] & ~btn_s2_ff[0];

    ////////////////////////////////////////////////////////////////////////
    // Settings and menu
    reg [4:0] menu_ff;
    reg [4:0] nxt_menu;
    reg signed [15:0] thr_ff [0:3];
    reg signed [15:0] make_ff;
    reg signed [15:0] break_ff;
    reg [3:0] band_ff;
    reg pump_ff;
    reg [3:0] pol_ff;
    integer k;

    function signed [15:0] spra_step;
        input signed [15:0] v;
        input up;
        input signed [15:0] lo;
        input signed [15:0] hi;
        begin
            if (up)
                spra_step = (v >= hi) ? hi : v + 16'sh0001;
            else
                spra_step = (v <= lo) ? lo : v - 16'sh0001;
        end
    endfunction

    always @* begin
        nxt_menu = menu_ff;
        case (menu_ff)
            `SPRA_M_IDLE: begin
                if (combo_rise)
                    nxt_menu = `SPRA_M_T1_VAL;
            end
            `SPRA_M_POL4: begin
                if (prog_rise)
                    nxt_menu = `SPRA_M_IDLE;
            end
            default: begin
                if (prog_rise)
                    nxt_menu = menu_ff + 5'h01;
            end
        endcase
    end

    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            menu_ff <= `SPRA_M_IDLE;
            for (k = 0; k < 4; k = k + 1)
                thr_ff[k] <= `SPRA_THR_RST;
            make_ff <= `SPRA_DLY_RST;
            break_ff <= `SPRA_DLY_RST;
            band_ff <= 4'h0;
            pump_ff <= 1'b0;
            pol_ff <= `SPRA_POL_RST;
        end else begin
            menu_ff <= nxt_menu;
            if (up_rise | down_rise) begin
                case (menu_ff)
                    `SPRA_M_T1_VAL: thr_ff[0] <= spra_step(thr_ff[0],
                        up_rise, `SPRA_VAL_MIN, `SPRA_VAL_MAX);
                    `SPRA_M_T2_VAL: thr_ff[1] <= spra_step(thr_ff[1],
                        up_rise, `SPRA_VAL_MIN, `SPRA_VAL_MAX);
                    `SPRA_M_T3_VAL: thr_ff[2] <= spra_step(thr_ff[2],
                        up_rise, `SPRA_VAL_MIN, `SPRA_VAL_MAX);
                    `SPRA_M_T4_VAL: thr_ff[3] <= spra_step(thr_ff[3],
                        up_rise, `SPRA_VAL_MIN, `SPRA_VAL_MAX);
                    `SPRA_M_T1_MAKE: make_ff <= spra_step(make_ff,
                        up_rise, `SPRA_DLY_MIN, `SPRA_DLY_MAX);
                    `SPRA_M_T1_BREAK: break_ff <= spra_step(break_ff,
                        up_rise, `SPRA_DLY_MIN, `SPRA_DLY_MAX);
                    `SPRA_M_T1_BAND: band_ff[0] <= ~band_ff[0];
                    `SPRA_M_T2_BAND: band_ff[1] <= ~band_ff[1];
                    `SPRA_M_T3_BAND: band_ff[2] <= ~band_ff[2];
                    `SPRA_M_T4_BAND: band_ff[3] <= ~band_ff[3];
                    `SPRA_M_T1_PUMP: pump_ff <= ~pump_ff;
                    `SPRA_M_POL1: pol_ff[0] <= ~pol_ff[0];
                    `SPRA_M_POL2: pol_ff[1] <= ~pol_ff[1];
                    `SPRA_M_POL3: pol_ff[2] <= ~pol_ff[2];
                    `SPRA_M_POL4: pol_ff[3] <= ~pol_ff[3];
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Display: label and value alternate until touched
    reg [31:0] blink_cnt_ff;
    reg blink_on_ff;
    reg label_ff;
    reg [15:0] value_ff;
    reg [15:0] nxt_value;

    always @* begin
        case (menu_ff)
            `SPRA_M_T1_VAL: nxt_value = thr_ff[0];
            `SPRA_M_T1_MAKE: nxt_value = make_ff;
            `SPRA_M_T1_BREAK: nxt_value = break_ff;
            `SPRA_M_T1_BAND: nxt_value = {15'h0000, band_ff[0]};
            `SPRA_M_T1_PUMP: nxt_value = {15'h0000, pump_ff};
            `SPRA_M_T2_VAL: nxt_value = thr_ff[1];
            `SPRA_M_T2_BAND: nxt_value = {15'h0000, band_ff[1]};
            `SPRA_M_T3_VAL: nxt_value = thr_ff[2];
            `SPRA_M_T3_BAND: nxt_value = {15'h0000, band_ff[2]};
            `SPRA_M_T4_VAL: nxt_value = thr_ff[3];
            `SPRA_M_T4_BAND: nxt_value = {15'h0000, band_ff[3]};
            `SPRA_M_POL1, `SPRA_M_POL2, `SPRA_M_POL3,
            `SPRA_M_POL4: nxt_value = {12'h000, pol_ff};
            default: nxt_value = 16'h0000;
        endcase
    end

    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            blink_cnt_ff <= 32'h00000000;
            blink_on_ff <= 1'b0;
            label_ff <= 1'b0;
            value_ff <= 16'h0000;
        end else begin
            value_ff <= nxt_value;
            if (nxt_menu == `SPRA_M_IDLE) begin
                blink_on_ff <= 1'b0;
                label_ff <= 1'b0;
                blink_cnt_ff <= 32'h00000000;
            end else if (nxt_menu != menu_ff) begin
                blink_on_ff <= 1'b1;
                label_ff <= 1'b1;
                blink_cnt_ff <= 32'h00000000;
            end else if (up_rise | down_rise) begin
                blink_on_ff <= 1'b0;
                label_ff <= 1'b0;
            end else if (blink_on_ff) begin
                if (blink_cnt_ff >= BLINK_CYCLES - 32'h00000001) begin
                    blink_cnt_ff <= 32'h00000000;
                    label_ff <= ~label_ff;
                end else begin
                    blink_cnt_ff <= blink_cnt_ff + 32'h00000001;
                end
            end
        end
    end

    assign menu_active_o = (menu_ff != `SPRA_M_IDLE);
    assign menu_item_o = menu_ff;
    assign disp_label_o = label_ff;
    assign disp_value_o = value_ff;

    ////////////////////////////////////////////////////////////////////////
    // Threshold comparators
    wire [3:0] alarm;
    wire pump_on;

    assign pump_on = pump_ff & (thr_ff[1] > thr_ff[0]);

    generate
        for (g = 0; g < 4; g = g + 1) begin : g_cmp
            spra_cmp u_cmp (
                .clock_i(clock_i),
                .rst_n_i(rst_n),
                .sample_i(reading_valid_i),
                .reading_i(reading_i),
                .thr_i(thr_ff[g]),
                .upper_thr_i(thr_ff[1]),
                .band_enable_i(band_ff[g]),
                .band_width_i(band_width_i),
                .high_pol_i(pol_ff[g]),
                .pump_band_mode_i((g == 0) ? pump_on : 1'b0),
                .alarm_o(alarm[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Relay one make and break delays
    reg [31:0] tick_cnt_ff;
    reg [15:0] sec_cnt_ff;
    reg relay1_ff;
    wire [15:0] delay_sel;

    assign delay_sel = relay1_ff ? break_ff : make_ff;

    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_ff <= 32'h00000000;
            sec_cnt_ff <= 16'h0000;
            relay1_ff <= 1'b0;
        end else if (alarm[0] == relay1_ff) begin
            tick_cnt_ff <= 32'h00000000;
            sec_cnt_ff <= 16'h0000;
        end else if (sec_cnt_ff >= delay_sel) begin
            relay1_ff <= alarm[0];
            tick_cnt_ff <= 32'h00000000;
            sec_cnt_ff <= 16'h0000;
        end else if (tick_cnt_ff >= TICK_CYCLES - 32'h00000001) begin
            tick_cnt_ff <= 32'h00000000;
            sec_cnt_ff <= sec_cnt_ff + 16'h0001;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
        end
    end

    assign relay_o = {alarm[3:1], relay1_ff};
    assign lamp_o = {alarm[3:1], relay1_ff};
endmodule // spra_top

// >>> tb/spra_top_assertions.sv
module spra_top_assertions (
    input wire clock_i,
    input wire rst_n_i,
    input wire reading_valid_i,
    input wire signed [15:0] reading_i,
    input wire [7:0] band_width_i,
    input wire btn_prog_i,
    input wire btn_up_i,
    input wire btn_down_i,
    input wire [3:0] relay_o,
    input wire [3:0] lamp_o,
    input wire menu_active_o,
    input wire [4:0] menu_item_o,
    input wire disp_label_o,
    input wire [15:0] disp_value_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    ////////////////////////////////////////////////////////////////////////
    a_lamp_follows: assert property (lamp_o == relay_o)
        else $error("lamps differ from relays");
    a_alarm_cause: assert property (
        $changed(relay_o[3:1]) |-> $past(reading_valid_i))
        else $error("alarm relay moved without a reading");
    a_menu_flag: assert property (
        menu_active_o == (menu_item_o != 5'h00))
        else $error("menu flag wrong");
    a_item_order: assert property ($changed(menu_item_o) |->
        menu_item_o == $past(menu_item_o) + 5'h01 ||
        ($past(menu_item_o) == 5'h0F && menu_item_o == 5'h00))
        else $error("menu left its order");
    a_entry_label: assert property ($rose(menu_active_o) |->
        disp_label_o && menu_item_o == 5'h01)
        else $error("menu entry without label");
    a_pol_width: assert property (menu_item_o >= 5'h0C &&
        $past(menu_item_o) >= 5'h0C |-> disp_value_o[15:4] == 12'h000)
        else $error("polarity value too wide");
    a_flag_value: assert property ((menu_item_o inside
        {5'h04, 5'h05, 5'h07, 5'h09, 5'h0B}) && $stable(menu_item_o) |->
        disp_value_o <= 16'h0001)
        else $error("on/off item not boolean");
    a_delay_range: assert property ((menu_item_o inside
        {5'h02, 5'h03}) && $stable(menu_item_o) |-> disp_value_o <= 16'h270F)
        else $error("delay out of range");
    a_value_range: assert property ((menu_item_o inside
        {5'h01, 5'h06, 5'h08, 5'h0A}) && $stable(menu_item_o) |->
        $signed(disp_value_o) >= 16'shF831 &&
        $signed(disp_value_o) <= 16'sh270F)
        else $error("threshold out of range");
    c_make: cover property ($rose(relay_o[0]));
    c_break: cover property ($fell(relay_o[0]));
    c_exit: cover property (menu_item_o == 5'h0F ##1 menu_item_o == 5'h00);
    c_alarm: cover property ($rose(relay_o[1]));
endmodule // spra_top_assertions

bind spra_top spra_top_assertions u_chk (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .reading_valid_i(reading_valid_i),
    .reading_i(reading_i), .band_width_i(band_width_i),
    .btn_prog_i(btn_prog_i), .btn_up_i(btn_up_i), .btn_down_i(btn_down_i),
    .relay_o(relay_o), .lamp_o(lamp_o), .menu_active_o(menu_active_o),
    .menu_item_o(menu_item_o), .disp_label_o(disp_label_o),
    .disp_value_o(disp_value_o)
);

// >>> tb/spra_operator.sv
module spra_operator (
    input wire clock_i,
    output logic btn_prog_o,
    output logic btn_up_o,
    output logic btn_down_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {btn_prog_o, btn_up_o, btn_down_o} = 3'h0;
    // Held well past the sync flops, released buttons read low
    task press(input logic [2:0] b);
        @(negedge clock_i);
        {btn_prog_o, btn_up_o, btn_down_o} = b;
        repeat (6) @(negedge clock_i);
        {btn_prog_o, btn_up_o, btn_down_o} = 3'h0;
        repeat (6) @(negedge clock_i);
    endtask
endmodule // spra_operator

// >>> tb/spra_top_tb_top.sv
module spra_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic reading_valid_i = 1'b0;
    logic signed [15:0] reading_i = 16'h0000;
    logic [7:0] band_width_i = 8'h02;
    wire bp, bu, bd, menu_active_o, disp_label_o;
    wire [3:0] relay_o, lamp_o;
    wire [4:0] menu_item_o;
    wire [15:0] disp_value_o;
    int failures = 0;
    int tests_run = 0;
    int seed = 43954;
    always #2 clock_i = ~clock_i;
    spra_top #(.TICK_CYCLES(32'd10), .BLINK_CYCLES(32'd4)) u_dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i),
        .reading_valid_i(reading_valid_i), .reading_i(reading_i),
        .band_width_i(band_width_i), .btn_prog_i(bp), .btn_up_i(bu),
        .btn_down_i(bd), .relay_o(relay_o), .lamp_o(lamp_o),
        .menu_active_o(menu_active_o), .menu_item_o(menu_item_o),
        .disp_label_o(disp_label_o), .disp_value_o(disp_value_o));
    spra_operator u_op (.clock_i(clock_i), .btn_prog_o(bp), .btn_up_o(bu),
        .btn_down_o(bd));
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic band_next(input int r, input int th, input int w,
        input logic prev);
        if (r > th + w) return 1'b1;
        if (r <= th - w) return 1'b0;
        return prev;
    endfunction
    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task pr(input logic [2:0] b, input int n);
        repeat (n) u_op.press(b);
    endtask
    task step(input logic [4:0] item, input logic [15:0] v);
        u_op.press(3'h4);
        chk(16'(menu_item_o), 16'(item));
        chk(disp_value_o, v);
    endtask
    task blinks(output int n);
        logic l;
        n = 0;
        l = disp_label_o;
        repeat (12) begin
            @(negedge clock_i);
            if (disp_label_o !== l) n++;
            l = disp_label_o;
        end
    endtask
    task read_in(input logic signed [15:0] r);
        @(negedge clock_i);
        reading_valid_i = 1'b1;
        reading_i = r;
        @(negedge clock_i);
        reading_valid_i = 1'b0;
        @(negedge clock_i);
    endtask
    task wait_rly(input logic v);
        for (int k = 0; k < 40 && relay_o[0] !== v; k++) @(negedge clock_i);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #200us;
        failures++;
        report_and_stop;
    end
    initial begin
        int n, ri, w;
        logic t2, t3;
        repeat (5) @(negedge clock_i);
        rst_n_i = 1'b1;
        repeat (3) @(negedge clock_i);
        chk(16'(relay_o), 16'h0000);
        u_op.press(3'h5);
        chk(16'(menu_item_o), 16'h0001);
        blinks(n);
        chk(16'(n > 0), 16'h0001);
        pr(3'h2, 1);
        chk(disp_value_o, 16'h270F);
        blinks(n);
        chk(16'(n), 16'h0000);
        pr(3'h1, 9);
        chk(disp_value_o, 16'h2706);
        step(5'h02, 16'h0000);
        pr(3'h2, 3);
        chk(disp_value_o, 16'h0003);
        step(5'h03, 16'h0000);
        pr(3'h2, 2);
        chk(disp_value_o, 16'h0002);
        step(5'h04, 16'h0000);
        pr(3'h2, 1);
        chk(disp_value_o, 16'h0001);
        pr(3'h2, 1);
        chk(disp_value_o, 16'h0000);
        step(5'h05, 16'h0000);
        step(5'h06, 16'h270F);
        pr(3'h1, 4);
        step(5'h07, 16'h0000);
        pr(3'h2, 1);
        step(5'h08, 16'h270F);
        pr(3'h1, 1);
        step(5'h09, 16'h0000);
        step(5'h0A, 16'h270F);
        step(5'h0B, 16'h0000);
        step(5'h0C, 16'h000F);
        step(5'h0D, 16'h000F);
        step(5'h0E, 16'h000F);
        step(5'h0F, 16'h000F);
        pr(3'h2, 1);
        chk(disp_value_o, 16'h0007);
        pr(3'h2, 1);
        u_op.press(3'h4);
        chk(16'(menu_item_o), 16'h0000);
        // Band edges first, then random readings biased near the edges
        t2 = 1'b0;
        for (int i = 0; i < 44; i++) begin
            if (i < 4) ri = (i == 0) ? 9997 : (i == 1) ? 9998 : 9995 - i / 3;
            else if (i % 2) ri = 9985 + $unsigned($random(seed)) % 15;
            else ri = $unsigned($random(seed)) % 11999 - 1999;
            if (i >= 4) band_width_i = 8'($unsigned($random(seed)) % 6);
            w = band_width_i;
            t2 = band_next(ri, 9995, w, t2);
            t3 = band_next(ri, 9998, 0, 1'b0);
            read_in(16'(ri));
            chk(16'(relay_o[3:1]), 16'({t3, t2}));
        end
        band_width_i = 8'h02;
        read_in(16'h0000);
        repeat (40) @(negedge clock_i);
        chk(16'(relay_o[0]), 16'h0000);
        read_in(16'h270F);
        repeat (20) @(negedge clock_i);
        read_in(16'h0000);
        read_in(16'h270F);
        repeat (25) @(negedge clock_i);
        chk(16'(relay_o[0]), 16'h0000);
        wait_rly(1'b1);
        chk(16'(lamp_o), 16'h0007);
        read_in(16'h0000);
        repeat (14) @(negedge clock_i);
        chk(16'(relay_o[0]), 16'h0001);
        wait_rly(1'b0);
        chk(16'(relay_o[0]), 16'h0000);
        // Pump band, drain: on above threshold two, off at threshold one
        u_op.press(3'h5);
        pr(3'h4, 4);
        pr(3'h2, 1);
        chk(disp_value_o, 16'h0001);
        pr(3'h4, 11);
        chk(16'(menu_item_o), 16'h0000);
        read_in(16'sd9993);
        repeat (40) @(negedge clock_i);
        chk(16'(relay_o[0]), 16'h0000);
        read_in(16'sd9997);
        wait_rly(1'b1);
        chk(16'(relay_o[0]), 16'h0001);
        read_in(16'sd9991);
        repeat (30) @(negedge clock_i);
        chk(16'(relay_o[0]), 16'h0001);
        read_in(16'sd9990);
        wait_rly(1'b0);
        chk(16'(relay_o[0]), 16'h0000);
        // Pump band, fill: threshold one switched to low activation
        u_op.press(3'h5);
        pr(3'h4, 11);
        pr(3'h2, 1);
        pr(3'h4, 4);
        chk(16'(menu_item_o), 16'h0000);
        read_in(16'sd9980);
        wait_rly(1'b1);
        chk(16'(relay_o[0]), 16'h0001);
        read_in(16'sd9993);
        repeat (30) @(negedge clock_i);
        chk(16'(relay_o[0]), 16'h0001);
        read_in(16'sd9995);
        wait_rly(1'b0);
        chk(16'(relay_o[0]), 16'h0000);
        rst_n_i = 1'b0;
        @(negedge clock_i);
        chk(16'({relay_o, menu_item_o}), 16'h0000);
        rst_n_i = 1'b1;
        repeat (3) @(negedge clock_i);
        report_and_stop;
    end
endmodule // spra_top_tb_top
